//--- hw/diag_defines.svh
// Purpose: offsets, field positions and constants of the diagnostic record block
// Assumes: Avalon-MM word addressing in bytes, 32-bit data
// Notes:   definitions only
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH

// register byte addresses
`define ADDR_REC_LO      5'h00
`define ADDR_REC_1       5'h04
`define ADDR_REC_2       5'h08
`define ADDR_REC_HI      5'h0C
`define ADDR_CTRL        5'h10
`define ADDR_STATUS      5'h14
`define ADDR_MASK        5'h18
`define ADDR_ERRIN       5'h1C

// record constants
`define CLASS_ANALOG     4'h5
`define CLASS_DIGITAL    4'hF
`define CHTYPE_DIN       7'h70
`define DIAG_BITS_PER_CH 8'h08
`define NUM_CHANNELS     8'h08
`define BYTE_ZERO        8'h00

// byte 0 / 1 / 2 / 3 bit positions
`define B0_MOD_FAIL      0
`define B0_EXT_ERR       2
`define B0_CH_ERR        3
`define B0_AUX_MISS      4
`define B1_CH_INFO       4
`define B2_SUPPLY_FAIL   4
`define B3_PI_LOST       6

// ctrl bits
`define CTRL_DIAG_EN     0
`define CTRL_MORE_TYPES  1

// status/mask bits
`define ST_INCOMING      0
`define ST_OUTGOING      1
`define ST_WIDTH         2

// read answer for unmapped addresses
`define READ_UNMAPPED    32'h0000_0000

`endif

//--- hw/diag_pkg.sv
// Purpose: types for the diagnostic record block
// Assumes: nothing
// Notes:   state of the top module kept as one packed struct
package diag_pkg;

    typedef enum logic [1:0] {
        idle_st,
        active_st
    } diag_state_type;

    typedef struct packed {
        diag_state_type state;
        logic [31:0]    rec_lo;
        logic [31:0]    rec_1;
        logic [31:0]    rec_2;
        logic [31:0]    rec_hi;
        logic [1:0]     ctrl;
        logic [1:0]     status;
        logic [1:0]     mask;
        logic [4:0]     errin;
        logic [15:0]    in_lost;
        logic [15:0]    cnt_lost;
        logic           irq;
        logic           waitreq;
        logic           rd_valid;
        logic [31:0]    rdata;
        logic           outgoing;
    } diag_regs_type;

endpackage

//--- hw/lost_detect.sv
// Purpose: flags a process interrupt lost when an event repeats while pending
// Assumes: event and done are one-cycle pulses on sys_clk
// Notes:   one instance per event source
`timescale 1ns/1ps
`default_nettype none

module lost_detect (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // event side
    input  wire logic event_pulse,
    input  wire logic done_pulse,
    input  wire logic clear_lost,
    // result
    output logic      lost
);

    logic pending;

    // pending tracks the handling window; lost holds until handling ends,
    // so the outgoing record can follow once every source is served
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pending <= 1'b0;
            lost    <= 1'b0;
        end else begin
            if (event_pulse)
                pending <= 1'b1;
            else if (done_pulse)
                pending <= 1'b0;
            if (event_pulse && pending)
                lost <= 1'b1;
            else if (clear_lost || done_pulse)
                lost <= 1'b0; // a repeat in the same cycle still wins
        end
    end

endmodule
`default_nettype wire

//--- hw/diag_records.sv
// Purpose: diagnostic record generator for a digital input and counter module
// Assumes: event inputs are synchronous one-cycle pulses; error levels are pins
// Notes:   records sit in four read-only words behind Avalon-MM
//
// Operation
// - byte 0 bits 0,2,3,4 flag failure, external, channel, aux supply; rest zero.
// - byte 1 holds module class in 3..0, channel info in bit 4.
// - incoming byte 2 bit 4 flags internal supply failure from overload.
// - incoming byte 3 bit 6 flags a lost process interrupt.
// - after errors clear with diagnostics enabled, outgoing record has bytes 2,3 zero.
// - extended record is 16 bytes, first four repeat basic record.
// - extended byte 4 holds channel type 70h, bit 7 more types.
// - extended bytes 5 and 6 both return 08h.
// - extended byte 7 flags errors per input group and per counter group.
// - bytes 8 to 11 flag lost input interrupts on even bits.
// - bytes 12 to 15 flag lost counter events on even bits.
// - last diagnostic record stays readable while diagnostics are disabled.
// - repeated process interrupt for a pending event raises a diagnostic.
`timescale 1ns/1ps
`default_nettype none
`include "diag_defines.svh"

module diag_records
    import diag_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // error level pins
    input  wire logic        module_fail_pin,
    input  wire logic        ext_err_pin,
    input  wire logic        aux_missing_pin,
    input  wire logic        supply_fail_pin,
    // process interrupt events and their completion
    input  wire logic [15:0] input_event,
    input  wire logic [15:0] input_done,
    input  wire logic [15:0] counter_event,
    input  wire logic [15:0] counter_done,
    // interrupt
    output logic             irq
);

    diag_regs_type r;
    diag_regs_type next_r;

    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [15:0] in_lost_w;
    logic [15:0] cnt_lost_w;
    logic        clear_lost;

    // two-flop synchroniser for the error pins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= {supply_fail_pin, aux_missing_pin, ext_err_pin, module_fail_pin};
            pin_s2 <= pin_s1;
        end
    end

    // lost flags are cleared once the outgoing record has been written
    assign clear_lost = r.outgoing;

    // one detector per input and per counter event
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_in
            lost_detect u_in (
                .sys_clk     (sys_clk),
                .rstn        (rstn),
                .event_pulse (input_event[g]),
                .done_pulse  (input_done[g]),
                .clear_lost  (clear_lost),
                .lost        (in_lost_w[g])
            );
            lost_detect u_cnt (
                .sys_clk     (sys_clk),
                .rstn        (rstn),
                .event_pulse (counter_event[g]),
                .done_pulse  (counter_done[g]),
                .clear_lost  (clear_lost),
                .lost        (cnt_lost_w[g])
            );
        end
    endgenerate

    // spread four flags onto even bits of a byte
    function automatic logic [7:0] even_bits(input logic [3:0] f);
        even_bits = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
    endfunction

    // next state: record assembly, bus slave, interrupt
    always_comb begin
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [7:0]  b3;
        logic [7:0]  grp;
        logic        any_err;
        logic        any_lost;
        logic [4:0]  err_now;
        logic [`ST_WIDTH-1:0] ev;
        logic        hit;
        logic        capture;
        logic [31:0] rd;
        b0       = `BYTE_ZERO;
        b1       = `BYTE_ZERO;
        b2       = `BYTE_ZERO;
        b3       = `BYTE_ZERO;
        grp      = `BYTE_ZERO;
        ev       = '0;
        hit      = 1'b1;
        capture  = 1'b0;
        rd       = `READ_UNMAPPED;
        next_r   = r;
        any_lost = |{in_lost_w, cnt_lost_w};
        // per-group channel errors: four input groups, four counter groups
        for (int i = 0; i < 4; i++) begin
            grp[i]     = |in_lost_w[i*4 +: 4];
            grp[i + 4] = |cnt_lost_w[i*4 +: 4];
        end
        any_err = |grp;
        err_now = {any_lost, pin_s2};

        // byte 0 to byte 3 layouts
        b0[`B0_MOD_FAIL] = pin_s2[0];
        b0[`B0_EXT_ERR]  = pin_s2[1];
        b0[`B0_CH_ERR]   = any_err;
        b0[`B0_AUX_MISS] = pin_s2[2];
        b1[3:0]          = `CLASS_DIGITAL;
        b1[`B1_CH_INFO]  = 1'b1;
        b2[`B2_SUPPLY_FAIL] = pin_s2[3];
        b3[`B3_PI_LOST]     = any_lost;

        next_r.outgoing = 1'b0;
        case (r.state)
            idle_st: begin
                if (|err_now) begin
                    capture      = 1'b1;
                    next_r.state = active_st;
                end
            end
            active_st: begin
                if (err_now == 5'h00) begin
                    // outgoing only when diagnostics still enabled; else record is kept
                    if (r.ctrl[`CTRL_DIAG_EN]) begin
                        next_r.rec_lo   = {`BYTE_ZERO, `BYTE_ZERO, b1, b0};
                        next_r.rec_1    = {grp, `NUM_CHANNELS, `DIAG_BITS_PER_CH,
                                           r.ctrl[`CTRL_MORE_TYPES], `CHTYPE_DIN};
                        next_r.rec_2    = '0;
                        next_r.rec_hi   = '0;
                        ev[`ST_OUTGOING] = 1'b1;
                    end
                    next_r.outgoing = 1'b1;
                    next_r.state    = idle_st;
                end else if ((err_now != r.errin) || (in_lost_w != r.in_lost) ||
                             (cnt_lost_w != r.cnt_lost)) begin
                    // a flag that comes or goes while active refreshes the record
                    capture = 1'b1;
                end
            end
            default: next_r.state = idle_st;
        endcase

        // incoming record, all four words in one update
        if (capture) begin
            next_r.rec_lo = {b3, b2, b1, b0};
            next_r.rec_1  = {grp, `NUM_CHANNELS, `DIAG_BITS_PER_CH,
                             r.ctrl[`CTRL_MORE_TYPES], `CHTYPE_DIN};
            next_r.rec_2  = {even_bits(in_lost_w[15:12]), even_bits(in_lost_w[11:8]),
                             even_bits(in_lost_w[7:4]), even_bits(in_lost_w[3:0])};
            next_r.rec_hi = {even_bits(cnt_lost_w[15:12]), even_bits(cnt_lost_w[11:8]),
                             even_bits(cnt_lost_w[7:4]), even_bits(cnt_lost_w[3:0])};
            if (r.ctrl[`CTRL_DIAG_EN])
                ev[`ST_INCOMING] = 1'b1;
        end

        // avalon slave: one wait cycle, answer on the second edge
        next_r.rd_valid = 1'b0;
        next_r.waitreq  = 1'b1;
        next_r.rdata    = `READ_UNMAPPED; // readdata is zero outside the answer cycle
        if ((read || write) && r.waitreq && !r.rd_valid) begin
            next_r.waitreq  = 1'b0;
            next_r.rd_valid = 1'b1;
            case (address)
                `ADDR_REC_LO: rd = r.rec_lo;
                `ADDR_REC_1:  rd = r.rec_1;
                `ADDR_REC_2:  rd = r.rec_2;
                `ADDR_REC_HI: rd = r.rec_hi;
                `ADDR_CTRL:   rd = {30'h0000_0000, r.ctrl};
                `ADDR_STATUS: rd = {30'h0000_0000, r.status};
                `ADDR_MASK:   rd = {30'h0000_0000, r.mask};
                `ADDR_ERRIN:  rd = {27'h000_0000, r.errin};
                default:      hit = 1'b0;
            endcase
            next_r.rdata = (read && hit) ? rd : `READ_UNMAPPED;
        end
        // a write lands only at the edge where waitrequest is seen low
        if (write && !r.waitreq && byteenable[0]) begin
            case (address)
                `ADDR_CTRL:   next_r.ctrl   = writedata[1:0];
                `ADDR_MASK:   next_r.mask   = writedata[1:0];
                `ADDR_STATUS: next_r.status = r.status & ~writedata[1:0];
                default:      next_r.ctrl   = next_r.ctrl;
            endcase
        end
        // event set wins over write-one clear
        next_r.status = next_r.status | ev;
        next_r.errin  = err_now;
        next_r.in_lost  = in_lost_w;
        next_r.cnt_lost = cnt_lost_w;
        next_r.irq    = |(next_r.status & next_r.mask);
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r         <= '0;
            r.state   <= idle_st;
            r.waitreq <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign readdata    = r.rdata;
    assign waitrequest = r.waitreq;
    assign irq         = r.irq;

endmodule
`default_nettype wire

//--- dv/diag_records_chk.sv
// Purpose: bus timing and record layout assertions
// Assumes: sees only the ports of diag_records
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "diag_defines.svh"
module diag_records_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // avalon-mm
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // request taken, read answered at one address
    sequence req_taken; (read || write) && waitrequest; endsequence
    sequence rd_at(logic [4:0] a); read && !waitrequest && address == a; endsequence
    // bus handshake
    chk_answer_next:
        assert property (req_taken |=> !waitrequest) else $error("answer late");
    chk_answer_short:
        assert property (!waitrequest |=> waitrequest) else $error("answer too long");
    chk_idle_zero:
        assert property (waitrequest |-> readdata == 32'h0) else $error("idle readdata");
    // fixed fields of the records
    chk_byte0_fixed:
        assert property (rd_at(`ADDR_REC_LO) |-> readdata[1] == 1'b0 && readdata[7:5] == 3'h0)
        else $error("byte 0 fixed bits");
    chk_class_code:
        assert property (rd_at(`ADDR_REC_LO) |-> readdata[11:8] == `CLASS_DIGITAL && readdata[15:13] == 3'h0)
        else $error("byte 1 layout");
    chk_byte2_fixed:
        assert property (rd_at(`ADDR_REC_LO) |-> (readdata[23:16] & 8'hEF) == 8'h00) else $error("byte 2");
    chk_byte3_fixed:
        assert property (rd_at(`ADDR_REC_LO) |-> (readdata[31:24] & 8'hBF) == 8'h00) else $error("byte 3");
    chk_type_count:
        assert property (rd_at(`ADDR_REC_1) |-> readdata[6:0] == `CHTYPE_DIN && readdata[23:8] == 16'h0808)
        else $error("type or counts");
    chk_odd_zero:
        assert property (read && !waitrequest && address[4:3] == 2'h1 |-> (readdata & 32'hAAAA_AAAA) == 32'h0)
        else $error("odd lost bits");
endmodule
`default_nettype wire

//--- dv/host_model.sv
// Purpose: host processor reading diagnostic records
// Assumes: every request is answered
// Notes:   released lines are inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and answer
    input  wire logic        sys_clk,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    // request
    output logic [4:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable
);
    // idle bus at time zero
    initial begin
        {address, read, write, writedata, byteenable} = '0;
    end
    // one transfer held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= 4'hF;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d;
        address <= ~a;
    endtask
endmodule
`default_nettype wire

//--- dv/diag_records_test.sv
// Purpose: self-checking bench for diag_records
// Assumes: host_model drives the bus side
// Notes:   pins need two sync cycles plus one
`timescale 1ns/1ps
`default_nettype none
`include "diag_defines.svh"
module diag_records_test;
    logic        sys_clk, rstn, read, write, waitrequest, irq;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic        module_fail_pin, ext_err_pin, aux_missing_pin, supply_fail_pin;
    logic [15:0] input_event, input_done, counter_event, counter_done;
    int          n_mismatch, num_checks, cycles;
    // design and host
    diag_records i_dut (.sys_clk, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .module_fail_pin, .ext_err_pin, .aux_missing_pin, .supply_fail_pin,
        .input_event, .input_done, .counter_event, .counter_done, .irq);
    host_model i_host (.sys_clk, .readdata, .waitrequest, .address, .read, .write, .writedata, .byteenable);
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // compare helpers
    task automatic cmp_word(input logic [31:0] got, exp, msk);
        num_checks++;
        if ((got & msk) !== (exp & msk)) begin
            n_mismatch++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t irq %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, msk);
        i_host.xfer(1'b0, a, 32'h0, q);
        cmp_word(q, exp, msk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    // one pulse: 0 input event, 1 input done, 2 counter event, 3 counter done
    task automatic ev(input int k, input int i);
        @(posedge sys_clk);
        case (k)
            0: input_event[i] <= 1'b1;
            1: input_done[i] <= 1'b1;
            2: counter_event[i] <= 1'b1;
            default: counter_done[i] <= 1'b1;
        endcase
        @(posedge sys_clk);
        input_event <= '0;
        input_done <= '0;
        counter_event <= '0;
        counter_done <= '0;
    endtask
    task automatic set_pins(input logic v);
        @(posedge sys_clk);
        {module_fail_pin, ext_err_pin, aux_missing_pin, supply_fail_pin} <= {4{v}};
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask
    // record kept while diagnostics are off
    task automatic t_disabled;
        set_pins(1'b1);
        set_pins(1'b0);
        rd(`ADDR_REC_LO, 32'h0000_0015, 32'h0000_00FF);
        cmp_bit(irq, 1'b0);
    endtask
    // incoming then outgoing record, mask and clear
    task automatic t_pins;
        wr(`ADDR_CTRL, 32'h1);
        wr(`ADDR_MASK, 32'h3);
        set_pins(1'b1);
        rd(`ADDR_REC_LO, 32'h0010_1F15, 32'hFFFF_FFFF);
        set_pins(1'b0);
        rd(`ADDR_STATUS, 32'h3, 32'h3);
        rd(`ADDR_REC_LO, 32'h0000_1F00, 32'hFFFF_FFFF);
        rd(5'h02, 32'h0, 32'hFFFF_FFFF);
        cmp_bit(irq, 1'b1);
        wr(`ADDR_STATUS, 32'h3);
        repeat (2) @(posedge sys_clk);
        cmp_bit(irq, 1'b0);
    endtask
    // lost interrupts, one input handled in time
    task automatic t_lost;
        wr(`ADDR_CTRL, 32'h3);
        wr(`ADDR_MASK, 32'h1);
        ev(0, 0);
        ev(1, 0);
        ev(0, 0);
        ev(0, 5);
        ev(0, 5);
        ev(2, 11);
        ev(2, 11);
        repeat (4) @(posedge sys_clk);
        cmp_bit(irq, 1'b1);
        rd(`ADDR_REC_LO, 32'h4000_1F08, 32'hFFFF_FFFF);
        wr(`ADDR_REC_1, 32'hFFFF_FFFF);
        rd(`ADDR_REC_1, 32'h4208_08F0, 32'hFFFF_FFFF);
        rd(`ADDR_REC_2, 32'h0000_0400, 32'hFFFF_FFFF);
        rd(`ADDR_REC_HI, 32'h0040_0000, 32'hFFFF_FFFF);
        rd(`ADDR_ERRIN, 32'h0000_0010, 32'hFFFF_FFFF);
        // handling ends: losses clear and the outgoing record follows
        ev(1, 5);
        ev(3, 11);
        repeat (4) @(posedge sys_clk);
        rd(`ADDR_STATUS, 32'h3, 32'h3);
        rd(`ADDR_REC_LO, 32'h0000_1F00, 32'hFFFF_FFFF);
        rd(`ADDR_REC_HI, 32'h0, 32'hFFFF_FFFF);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        {module_fail_pin, ext_err_pin, aux_missing_pin, supply_fail_pin} = 4'h0;
        {input_event, input_done, counter_event, counter_done} = '0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_disabled();
        do_reset();
        t_pins();
        do_reset();
        t_lost();
        final_report();
    end
endmodule
bind diag_records diag_records_chk i_chk (.sys_clk, .rstn, .address, .read, .write, .readdata, .waitrequest);
`default_nettype wire
